// [ebw_pkg.sv]
// Package with constants, register map and types of the external bus wait and request block.
package ebw_pkg;
    localparam logic [11:0] EBW_CTRL_OFS = 12'h000;
    localparam logic [11:0] EBW_MODE_OFS = 12'h004;
    localparam logic [11:0] EBW_CMD_OFS = 12'h008;
    localparam logic [11:0] EBW_STAT_OFS = 12'h00C;
    localparam int EBW_WAIT_LSB = 0;
    localparam int EBW_WAIT_W = 5;
    localparam int EBW_HOLE_BIT = 8;
    localparam int EBW_DRAM_BIT = 9;
    localparam int EBW_SYNC_BIT = 0;
    localparam int EBW_CMD_START = 0;
    localparam int EBW_CMD_WRITE = 1;
    localparam int EBW_CMD_INTERNAL = 2;
    localparam logic [EBW_WAIT_W-1:0] EBW_WAIT_RST = 5'h01;
    localparam logic EBW_SYNC_RST = 1'b1;
    localparam int EBW_ACK_LAT_NS = 8;
    localparam int EBW_CLK_NS = 8;
    localparam int EBW_ACK_LAT_CYC = (EBW_ACK_LAT_NS + EBW_CLK_NS - 1) / EBW_CLK_NS;

    typedef enum logic [4:0] {
        EBW_SLAVE = 5'h01,
        EBW_WAIT_GRANT = 5'h02,
        EBW_WAIT_IDLE = 5'h04,
        EBW_MASTER = 5'h08,
        EBW_CYCLE = 5'h10
    } ebw_arb_e;

    typedef struct packed {
        logic wr_n_o;
        logic wr_n_oe;
        logic bb_n_o;
        logic bb_n_oe;
        logic br_n;
    } ebw_pins_s;
endpackage : ebw_pkg

// [ebw_sync3.sv]
// Three-flop input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module ebw_sync3 (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pin level and its settled copy.
    input wire logic din,
    output logic dout
);
    logic s1_r, s2_r, s3_r, dout_r, dout_nxt;
    always_comb begin
        dout_nxt = dout_r;
        if (s2_r == s3_r) begin
            dout_nxt = s3_r;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            dout_r <= 1'b1;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout_r <= dout_nxt;
        end
    end
    assign dout = dout_r;
endmodule : ebw_sync3
`default_nettype wire

// [ebw_regs.sv]
// APB register file of the external bus wait and request block.
`timescale 1ns/100ps
`default_nettype none
module ebw_regs
    import ebw_pkg::*;
(
    // APB.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Settings and status.
    output logic [EBW_WAIT_W-1:0] min_wait,
    output logic hole,
    output logic dram_acc,
    output logic ack_sync,
    output logic start_pulse,
    output logic start_write,
    output logic start_internal,
    input wire logic [7:0] status
);
    logic [EBW_WAIT_W-1:0] wait_r, wait_nxt;
    logic hole_r, hole_nxt, dram_r, dram_nxt, sync_r, sync_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic err_r, err_nxt, st_r, st_nxt, stw_r, stw_nxt, sti_r, sti_nxt;
    logic acc, wr_en;
    assign acc = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    always_comb begin
        wait_nxt = wait_r;
        hole_nxt = hole_r;
        dram_nxt = dram_r;
        sync_nxt = sync_r;
        rd_nxt = 32'h00000000;
        err_nxt = 1'b0;
        st_nxt = 1'b0;
        stw_nxt = stw_r;
        sti_nxt = sti_r;
        if (psel) begin
            unique case (paddr)
                EBW_CTRL_OFS: begin
                    if (wr_en) begin
                        wait_nxt = pwdata[EBW_WAIT_LSB +: EBW_WAIT_W];
                        hole_nxt = pwdata[EBW_HOLE_BIT];
                        dram_nxt = pwdata[EBW_DRAM_BIT];
                    end
                    rd_nxt[EBW_WAIT_LSB +: EBW_WAIT_W] = wait_r;
                    rd_nxt[EBW_HOLE_BIT] = hole_r;
                    rd_nxt[EBW_DRAM_BIT] = dram_r;
                end
                EBW_MODE_OFS: begin
                    if (wr_en) begin
                        sync_nxt = pwdata[EBW_SYNC_BIT];
                    end
                    rd_nxt[EBW_SYNC_BIT] = sync_r;
                end
                EBW_CMD_OFS: begin
                    if (wr_en) begin
                        st_nxt = pwdata[EBW_CMD_START];
                        stw_nxt = pwdata[EBW_CMD_WRITE];
                        sti_nxt = pwdata[EBW_CMD_INTERNAL];
                    end
                end
                EBW_STAT_OFS: begin
                    rd_nxt[7:0] = status;
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= EBW_WAIT_RST;
            hole_r <= 1'b0;
            dram_r <= 1'b0;
            sync_r <= EBW_SYNC_RST;
            rd_r <= 32'h00000000;
            err_r <= 1'b0;
            st_r <= 1'b0;
            stw_r <= 1'b0;
            sti_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
            hole_r <= hole_nxt;
            dram_r <= dram_nxt;
            sync_r <= sync_nxt;
            if (acc) begin
                rd_r <= rd_nxt;
                err_r <= err_nxt;
            end
            st_r <= st_nxt;
            stw_r <= stw_nxt;
            sti_r <= sti_nxt;
        end
    end
    // Writes land at the access edge; read data is captured at setup, so no wait state is needed.
    assign pready = 1'b1;
    assign prdata = rd_r;
    assign pslverr = psel && penable && err_r;
    assign min_wait = wait_r;
    assign hole = hole_r;
    assign dram_acc = dram_r;
    assign ack_sync = sync_r;
    assign start_pulse = st_r;
    assign start_write = stw_r;
    assign start_internal = sti_r;
endmodule : ebw_regs
`default_nettype wire

// [ebw_top.sv]
// Top level of the external bus wait, write strobe and bus request block.
// Notes on behaviour
// - Write strobe driven low during an external write while bus master.
// - Write strobe released when not bus master and during reset.
// - Acknowledge ignored when not master, no cycle active, or in reset.
// - With a non-zero minimum wait and dram_acc clear, external cycle stays open while acknowledge stays deasserted.
// - Synchronous acknowledge ends the cycle one clock later.
// - With a non-zero minimum and dram_acc clear, wait count is the longer of acknowledge count and programmed minimum.
// - Acknowledge-sync select bit picks synchronous or asynchronous acknowledge.
// - Bus request is always driven, never released.
// - Bus request asserted while the bus is needed or the request-hole bit is set, released when neither.
// - Bus request may change whether master or slave.
// - Parking: request may drop while the device keeps mastership.
// - Request-hole bit forces bus request asserted without need.
// - Only external bus demands and the request-hole bit raise bus request.
// - Reset holds bus request high and arbitration in slave state.
// - After grant, wait for bus busy release before taking the bus.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ebw_top
    import ebw_pkg::*;
(
    // APB.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External bus pins.
    input wire logic transfer_ack_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n_i,
    output ebw_pins_s pins,
    // Cycle status.
    output logic cycle_done
);
    logic [EBW_WAIT_W-1:0] min_wait;
    logic hole, dram_acc, ack_sync, start_pulse, start_write, start_internal;
    logic ack_async, gnt_n, bb_n;
    logic [7:0] status;

    ebw_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .min_wait(min_wait),
        .hole(hole),
        .dram_acc(dram_acc),
        .ack_sync(ack_sync),
        .start_pulse(start_pulse),
        .start_write(start_write),
        .start_internal(start_internal),
        .status(status)
    );

    // Grant and busy are synchronous to the core clock, so no synchroniser.
    assign gnt_n = bus_grant_n;
    assign bb_n = bus_busy_n_i;

    ebw_sync3 u_ack_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(transfer_ack_n),
        .dout(ack_async)
    );

    ebw_arb_e st_r, st_nxt;
    logic pend_r, pend_nxt, pwr_r, pwr_nxt, cwr_r, cwr_nxt, done_r, done_nxt;
    logic [EBW_WAIT_W-1:0] wcnt_r, wcnt_nxt;
    logic br_r, br_nxt, ack_n, need, master;

    // The asynchronous path costs four cycles of latency per acknowledge.
    assign ack_n = ack_sync ? transfer_ack_n : ack_async;
    assign need = pend_r;
    assign master = (st_r == EBW_MASTER) || (st_r == EBW_CYCLE);

    always_comb begin
        st_nxt = st_r;
        pend_nxt = pend_r;
        pwr_nxt = pwr_r;
        cwr_nxt = cwr_r;
        wcnt_nxt = wcnt_r;
        done_nxt = 1'b0;
        if (start_pulse && !start_internal && !pend_r) begin
            pend_nxt = 1'b1;
            pwr_nxt = start_write;
        end
        unique case (st_r)
            EBW_SLAVE: begin
                if (pend_r) begin
                    st_nxt = EBW_WAIT_GRANT;
                end
            end
            EBW_WAIT_GRANT: begin
                if (!gnt_n) begin
                    st_nxt = EBW_WAIT_IDLE;
                end
            end
            EBW_WAIT_IDLE: begin
                if (gnt_n) begin
                    st_nxt = EBW_WAIT_GRANT;
                end else if (bb_n) begin
                    st_nxt = EBW_MASTER;
                end
            end
            EBW_MASTER: begin
                if (gnt_n) begin
                    st_nxt = EBW_SLAVE;
                end else if (pend_r) begin
                    st_nxt = EBW_CYCLE;
                    pend_nxt = 1'b0;
                    cwr_nxt = pwr_r;
                    wcnt_nxt = '0;
                end
            end
            EBW_CYCLE: begin
                if (wcnt_r != {EBW_WAIT_W{1'b1}}) begin
                    wcnt_nxt = wcnt_r + 1'b1;
                end
                // Wait states below the minimum are always taken; past it the
                // acknowledge decides unless dram_acc is set, and a zero minimum cannot be stretched.
                if (wcnt_r >= min_wait && (min_wait == '0 || dram_acc || !ack_n)) begin
                    st_nxt = EBW_MASTER;
                    done_nxt = 1'b1;
                    cwr_nxt = 1'b0;
                end
            end
            default: begin
                st_nxt = EBW_SLAVE;
            end
        endcase
    end

    // Parking: request follows need and the hole bit only, so mastership can outlive it.
    always_comb begin
        br_nxt = !(need || hole);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= EBW_SLAVE;
            pend_r <= 1'b0;
            pwr_r <= 1'b0;
            cwr_r <= 1'b0;
            wcnt_r <= '0;
            done_r <= 1'b0;
            br_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            pend_r <= pend_nxt;
            pwr_r <= pwr_nxt;
            cwr_r <= cwr_nxt;
            wcnt_r <= wcnt_nxt;
            done_r <= done_nxt;
            br_r <= br_nxt;
        end
    end

    assign pins.br_n = br_r;
    assign pins.wr_n_o = !((st_r == EBW_CYCLE) && cwr_r);
    assign pins.wr_n_oe = master;
    assign pins.bb_n_o = 1'b0;
    assign pins.bb_n_oe = master;
    assign cycle_done = done_r;
    assign status = {2'b00, pend_r, st_r};

    sequence cycle_open_s;
        st_r == EBW_CYCLE && wcnt_r >= min_wait && min_wait != '0 && !dram_acc;
    endsequence

    slave_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        !master |-> !pins.wr_n_oe) else $error("write strobe driven as slave");
    wr_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pins.wr_n_o |-> master && cwr_r) else $error("write strobe low outside write");
    stretch_a: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_open_s and ack_n |=> st_r == EBW_CYCLE) else $error("cycle ended early");
    ack_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_open_s and !ack_n |=> done_r && st_r == EBW_MASTER)
        else $error("acknowledge did not end cycle");
    min_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == EBW_CYCLE && wcnt_r < min_wait |=> st_r == EBW_CYCLE)
        else $error("minimum wait cut short");
    ack_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r != EBW_CYCLE |=> !done_r) else $error("done outside cycle");
    hole_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        hole |=> !pins.br_n) else $error("request hole not honoured");
    req_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !need && !hole |=> pins.br_n) else $error("request without need");
    grant_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == EBW_WAIT_IDLE && !bb_n |=> !master) else $error("took busy bus");
endmodule : ebw_top
`default_nettype wire

// [ebw_far_model.sv]
// Model of the external arbiter and the acknowledging memory on the far side of the port.
`timescale 1ns/100ps
`default_nettype none
module ebw_far_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Device side.
    input wire logic br_n,
    input wire logic mastered,
    input wire logic cycle_done,
    // Bench control.
    input wire logic kick,
    input wire logic grant_en,
    input wire logic other_busy,
    input wire logic [7:0] dly,
    // Driven pins.
    output logic bus_grant_n,
    output logic bus_busy_n_i,
    output logic transfer_ack_n
);
    logic armed;
    logic [7:0] cnt;
    // Busy has a pull-up, so it reads high unless another master holds it low.
    assign bus_busy_n_i = !other_busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_grant_n <= 1'b1;
            armed <= 1'b0;
            cnt <= 8'h00;
            transfer_ack_n <= 1'b1;
        end else begin
            // Grant is kept while enabled, so the device may park on the bus.
            bus_grant_n <= !(grant_en && (!br_n || !bus_grant_n));
            armed <= kick ? 1'b1 : (cycle_done ? 1'b0 : armed);
            cnt <= kick ? 8'h00 : ((mastered && armed) ? cnt + 8'h01 : cnt);
            // High at the start of a cycle, low to finish it, high again before the next.
            transfer_ack_n <= !(armed && !kick && !cycle_done && cnt >= dly);
        end
    end
endmodule : ebw_far_model
`default_nettype wire

// [ext_bus_wait_and_request_tb.sv]
// Self-checking testbench of the external bus wait and request block.
`timescale 1ns/100ps
`default_nettype none
module ext_bus_wait_and_request_tb;
    import ebw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic transfer_ack_n, bus_grant_n, bus_busy_n_i, kick, grant_en, other_busy, e, w;
    logic [7:0] dly;
    ebw_pins_s pins;
    int err_total = 0;
    int check_count = 0;
    int na, nb, nc, nd, nf, ng;

    ebw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .transfer_ack_n(transfer_ack_n), .bus_grant_n(bus_grant_n),
        .bus_busy_n_i(bus_busy_n_i), .pins(pins), .cycle_done(cycle_done));
    ebw_far_model u_far (.pclk(pclk), .presetn(presetn), .br_n(pins.br_n),
        .mastered(pins.wr_n_oe), .cycle_done(cycle_done), .kick(kick), .grant_en(grant_en),
        .other_busy(other_busy), .dly(dly), .bus_grant_n(bus_grant_n),
        .bus_busy_n_i(bus_busy_n_i), .transfer_ack_n(transfer_ack_n));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Pready is sampled at each access edge; the request is held until it is high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // Starts one external cycle and counts clocks until it is reported finished.
    task automatic xfer(input logic [2:0] cmd, output int n);
        apb(1'b1, EBW_CMD_OFS, {29'h0, cmd});
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        n = 0;
        w = 1'b0;
        while (cycle_done !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
            if (n == 8 && other_busy) chk("oe_while_busy", pins.wr_n_oe, 1'b0);
            if (n == 12) other_busy <= 1'b0;
            if (pins.wr_n_oe === 1'b1 && pins.wr_n_o === 1'b0) w = 1'b1;
        end
        if (n >= 1000) chk("cycle_done", 1'b0, 1'b1);
        chk("bb_drive", {pins.bb_n_oe, pins.bb_n_o}, 2'b10);
    endtask : xfer

    task automatic t_reset();
        apb(1'b0, EBW_CTRL_OFS, 32'h0);
        chk("ctrl_rst", q, 32'h00000001);
        apb(1'b0, EBW_MODE_OFS, 32'h0);
        chk("mode_rst", q, 32'h00000001);
        apb(1'b0, EBW_STAT_OFS, 32'h0);
        chk("state_rst", {27'h0, q[4:0]}, 32'h00000001);
        chk("br_rst", pins.br_n, 1'b1);
        chk("wr_oe_rst", pins.wr_n_oe, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", e, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cycles();
        other_busy <= 1'b1;
        xfer(3'h3, na);
        chk("wr_strobe", w, 1'b1);
        dly <= 8'h02;
        xfer(3'h1, na);
        chk("rd_no_strobe", w, 1'b0);
        dly <= 8'h06;
        xfer(3'h1, nb);
        chk("ack_stretch", nb - na, 4);
        chk("parked_br", pins.br_n, 1'b1);
        apb(1'b0, EBW_STAT_OFS, 32'h0);
        chk("parked_state", {27'h0, q[4:0]}, 32'h00000008);
        dly <= 8'h01;
        apb(1'b1, EBW_CTRL_OFS, 32'h00000014);
        xfer(3'h1, nc);
        apb(1'b1, EBW_CTRL_OFS, 32'h00000018);
        xfer(3'h1, nd);
        chk("min_wait", nd - nc, 4);
        apb(1'b1, EBW_CTRL_OFS, 32'h00000203);
        dly <= 8'h20;
        xfer(3'h1, ng);
        chk("dram_no_stretch", ng, nc - 17);
        apb(1'b1, EBW_CTRL_OFS, 32'h00000001);
        dly <= 8'h02;
        apb(1'b1, EBW_MODE_OFS, 32'h0);
        xfer(3'h1, nf);
        chk("async_later", nf > na, 1'b1);
        apb(1'b1, EBW_MODE_OFS, 32'h00000001);
        $display("test cycles done");
    endtask : t_cycles

    task automatic t_request();
        grant_en <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, EBW_CMD_OFS, 32'h00000005);
        repeat (8) @(posedge pclk);
        chk("internal_no_br", pins.br_n, 1'b1);
        apb(1'b1, EBW_CTRL_OFS, 32'h00000101);
        repeat (3) @(posedge pclk);
        chk("hole_br", pins.br_n, 1'b0);
        apb(1'b1, EBW_CTRL_OFS, 32'h00000001);
        apb(1'b1, EBW_CMD_OFS, 32'h00000003);
        repeat (3) @(posedge pclk);
        chk("slave_br", pins.br_n, 1'b0);
        do_reset();
        chk("mid_rst_br", pins.br_n, 1'b1);
        chk("mid_rst_oe", pins.wr_n_oe, 1'b0);
        apb(1'b0, EBW_STAT_OFS, 32'h0);
        chk("mid_rst_state", {27'h0, q[4:0]}, 32'h00000001);
        $display("test request done");
    endtask : t_request

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        kick = 1'b0;
        grant_en = 1'b1;
        other_busy = 1'b0;
        dly = 8'h02;
        do_reset();
        t_reset();
        t_cycles();
        t_request();
        finish_test();
    end

    // The whole run needs a few hundred clocks; this bound only catches a hang.
    initial begin
        repeat (50000) @(posedge pclk);
        err_total++;
        finish_test();
    end
endmodule : ext_bus_wait_and_request_tb
`default_nettype wire
